// ---- design/t1fr_fifo.sv ----
// Parameterised valid/ready FIFO for the transmit channel bytes.
module t1fr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // Fill side
    input wire logic [WIDTH-1:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    // Drain side
    output logic [WIDTH-1:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    // Honest flags straight from the occupancy count
    assign in_ready_out = (count_reg != (AW+1)'(DEPTH));
    assign out_valid_out = (count_reg != '0);
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = mem[rd_ptr_reg];

    // Storage, no reset needed on data
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data_in;
        end
    end

    // Pointers and count
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : AW'(wr_ptr_reg + 1'b1);
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : AW'(rd_ptr_reg + 1'b1);
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

// ---- design/t1fr_framer.sv ----
// T1 framer for the data multiplex and loop-carrier superframe formats.
// Contract
// R1 - Data multiplex: one seven-bit user byte into each of the first 23 slots.
// R2 - Data multiplex: slot 24 always carries the synchronizing byte, never user data.
// R3 - Slot 24 bits 0-4 are 1,0,1,1,1, bit 7 is 0; receiver checks it.
// R4 - Slot 24 bit 5 is yellow alarm: 0 alarm, 1 no alarm.
// R5 - Slot 24 bit 6 carries one 8 kHz data link bit per frame.
// R6 - Data multiplex uses plain 12-frame superframe F-bits.
// R7 - Data multiplex: user bits 1-7 carry data, bit 8 reserved for network.
// R8 - Host should enable no zero substitution in data multiplex format.
// R9 - Data multiplex odd F-bits 1,0,1,0,1,0; even F-bits 0,0,1,1,1,0.
// R10 - Loop carrier: 72 frames, link bits in even frames 12-58.
// R11 - Loop carrier otherwise follows 12-frame superframe F-bit pattern.
// R12 - Robbed-bit signaling replaces channel LSB every sixth frame, A then B.
// R13 - Receive extracts yellow and link bit from slot 24, flags alarm on 0.
// R14 - Receive gathers loop-carrier link bits, presents them once per multiframe.
module t1fr_framer
    import t1fr_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // Mode: 1 selects data multiplex, 0 loop carrier
    input wire logic data_multiplex_format_in,
    // Transmit channel bytes from the system side
    input wire logic [7:0] tx_data_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out,
    // Transmit overhead
    input wire logic [23:0] tx_sig_a_in,
    input wire logic [23:0] tx_sig_b_in,
    input wire logic tx_yellow_alarm_in,
    input wire logic tx_dm_link_bit_in,
    input wire t1fr_link_t tx_link_in,
    // Transmit line side
    input wire logic tx_bit_req_in,
    output logic tx_bit_out,
    output logic tx_frame_start_out,
    // Receive line side
    input wire logic rx_bit_in,
    input wire logic rx_bit_valid_in,
    input wire logic rx_frame_sync_in,
    // Receive results
    output t1fr_chan_byte_t rx_byte_out,
    output logic rx_byte_valid_out,
    output logic rx_yellow_alarm_out,
    output logic rx_dm_link_bit_out,
    output logic rx_dm_link_valid_out,
    output logic rx_sync_error_out,
    output t1fr_link_t rx_link_out,
    output logic rx_link_valid_out
);
    // ==========================================================
    // Transmit byte buffer
    logic [7:0] fifo_data;
    logic fifo_valid, fifo_pop;
    t1fr_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .in_data_in(tx_data_in),
        .in_valid_in(tx_valid_in),
        .in_ready_out(tx_ready_out),
        .out_data_out(fifo_data),
        .out_valid_out(fifo_valid),
        .out_ready_in(fifo_pop)
    );
    // ==========================================================
    // Transmit position counters
    t1fr_phase_t tx_phase_reg;
    logic [6:0] tx_frame_reg, frame_last;
    logic [3:0] tx_sf_reg;
    logic [4:0] tx_slot_reg, tx_link_idx;
    logic [2:0] tx_bitpos_reg;
    logic [7:0] tx_byte_reg, tx_sync_live, tx_cur_byte;
    logic [23:0] tx_link_vec;
    logic tx_slot_start, tx_is_sync, tx_in_link, tx_link_bit, tx_rob_bit, tx_bit_next;
    // Wrap point follows the mode; a mode change settles within one multiframe
    assign frame_last = data_multiplex_format_in ? SF_LAST_FRAME : LOOP_LAST_FRAME;
    assign tx_slot_start = (tx_phase_reg == PH_CHAN) && (tx_bitpos_reg == '0);
    assign tx_is_sync = data_multiplex_format_in && (tx_slot_reg == SYNC_SLOT); // [R2]
    assign tx_in_link = !data_multiplex_format_in && tx_frame_reg[0]
                        && (tx_frame_reg >= LINK_FIRST) && (tx_frame_reg <= LINK_LAST);
    assign tx_link_idx = 5'((tx_frame_reg - LINK_FIRST) >> 1);
    assign tx_link_vec = t1fr_link_vec(tx_link_in);
    assign tx_link_bit = tx_link_vec[tx_link_idx]; // [R10]
    assign tx_rob_bit = (tx_sf_reg == SF_SIG_A) ? tx_sig_a_in[tx_slot_reg]
                                                : tx_sig_b_in[tx_slot_reg];
    // User byte is taken only at the first bit of a user slot
    assign fifo_pop = tx_bit_req_in && tx_slot_start && !tx_is_sync && fifo_valid; // [R1] [R2]

    // Live slot-24 byte so alarm and link reflect the frame being sent
    always_comb begin
        tx_sync_live = SYNC_BYTE; // [R3]
        tx_sync_live[YEL_POS] = !tx_yellow_alarm_in; // [R4]
        tx_sync_live[DL_POS] = tx_dm_link_bit_in; // [R5]
    end
    // Byte in the current slot; empty buffer sends idle ones
    always_comb begin
        if (!tx_slot_start) begin
            tx_cur_byte = tx_byte_reg;
        end else if (tx_is_sync) begin
            tx_cur_byte = tx_sync_live;
        end else if (fifo_valid) begin
            tx_cur_byte = fifo_data;
        end else begin
            tx_cur_byte = IDLE_BYTE;
        end
    end
    // Line bit selection
    always_comb begin
        if (tx_phase_reg == PH_FBIT) begin
            if (!tx_frame_reg[0]) begin
                tx_bit_next = (tx_frame_reg[1:0] == 2'b00); // [R9] [R10]
            end else if (tx_in_link) begin
                tx_bit_next = tx_link_bit; // [R10]
            end else begin
                tx_bit_next = FS_PATTERN[tx_sf_reg]; // [R6] [R9] [R11]
            end
        end else if (tx_is_sync) begin
            tx_bit_next = tx_cur_byte[tx_bitpos_reg]; // [R3]
        end else if (data_multiplex_format_in) begin
            // Bit 8 kept at one: reserved for network, and helps ones density
            tx_bit_next = (tx_bitpos_reg == RES_BIT) ? 1'b1
                          : tx_cur_byte[3'(DM_MSB - tx_bitpos_reg)]; // [R7]
        end else if ((tx_bitpos_reg == LAST_BIT)
                     && ((tx_sf_reg == SF_SIG_A) || (tx_sf_reg == SF_SIG_B))) begin
            tx_bit_next = tx_rob_bit; // [R12]
        end else begin
            tx_bit_next = tx_cur_byte[3'(LAST_BIT - tx_bitpos_reg)];
        end
    end
    // Position advance per line bit request
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            tx_phase_reg <= PH_FBIT;
            tx_frame_reg <= '0;
            tx_sf_reg <= '0;
            tx_slot_reg <= '0;
            tx_bitpos_reg <= '0;
        end else if (tx_bit_req_in) begin
            if (tx_phase_reg == PH_FBIT) begin
                tx_phase_reg <= PH_CHAN;
                tx_slot_reg <= '0;
                tx_bitpos_reg <= '0;
            end else if (tx_bitpos_reg != LAST_BIT) begin
                tx_bitpos_reg <= tx_bitpos_reg + 1'b1;
            end else if (tx_slot_reg != LAST_SLOT) begin
                tx_bitpos_reg <= '0;
                tx_slot_reg <= tx_slot_reg + 1'b1;
            end else begin
                tx_phase_reg <= PH_FBIT;
                tx_frame_reg <= (tx_frame_reg >= frame_last) ? '0 : tx_frame_reg + 1'b1;
                tx_sf_reg <= (tx_sf_reg >= SF_LAST) ? '0 : tx_sf_reg + 1'b1;
            end
        end
    end
    // Line outputs and slot byte hold
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            tx_bit_out <= 1'b1;
            tx_frame_start_out <= 1'b0;
            tx_byte_reg <= IDLE_BYTE;
        end else begin
            tx_frame_start_out <= tx_bit_req_in && (tx_phase_reg == PH_FBIT)
                                  && (tx_frame_reg == '0);
            if (tx_bit_req_in) begin
                tx_bit_out <= tx_bit_next;
                tx_byte_reg <= tx_cur_byte;
            end
        end
    end

    // ==========================================================
    // Receive position counters
    t1fr_phase_t rx_phase_reg;
    logic [6:0] rx_frame_reg, rx_shift_reg;
    logic [4:0] rx_slot_reg, rx_link_idx;
    logic [2:0] rx_bitpos_reg;
    logic [22:0] rx_shadow_reg;
    logic [7:0] rx_full, rx_rev;
    logic rx_fbit, rx_slot_done, rx_ch24_done, rx_in_link;
    assign rx_fbit = rx_frame_sync_in || (rx_phase_reg == PH_FBIT);
    assign rx_slot_done = rx_bit_valid_in && !rx_fbit && (rx_bitpos_reg == LAST_BIT);
    assign rx_ch24_done = rx_slot_done && data_multiplex_format_in
                          && (rx_slot_reg == SYNC_SLOT);
    assign rx_in_link = !data_multiplex_format_in && !rx_frame_sync_in && rx_frame_reg[0]
                        && (rx_frame_reg >= LINK_FIRST) && (rx_frame_reg <= LINK_LAST);
    assign rx_link_idx = 5'((rx_frame_reg - LINK_FIRST) >> 1);
    assign rx_full = {rx_shift_reg, rx_bit_in};

    // Slot 24 is sent bit 0 first, so flip the arrival order
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_rev
            assign rx_rev[g] = rx_full[7 - g];
        end
    endgenerate
    // Sync pulse forces frame 1, F-bit position, from the outside aligner
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rx_phase_reg <= PH_FBIT;
            rx_frame_reg <= '0;
            rx_slot_reg <= '0;
            rx_bitpos_reg <= '0;
        end else if (rx_bit_valid_in) begin
            if (rx_fbit) begin
                rx_phase_reg <= PH_CHAN;
                rx_slot_reg <= '0;
                rx_bitpos_reg <= '0;
                if (rx_frame_sync_in) begin
                    rx_frame_reg <= '0;
                end
            end else if (rx_bitpos_reg != LAST_BIT) begin
                rx_bitpos_reg <= rx_bitpos_reg + 1'b1;
            end else if (rx_slot_reg != LAST_SLOT) begin
                rx_bitpos_reg <= '0;
                rx_slot_reg <= rx_slot_reg + 1'b1;
            end else begin
                rx_phase_reg <= PH_FBIT;
                rx_frame_reg <= (rx_frame_reg >= frame_last) ? '0 : rx_frame_reg + 1'b1;
            end
        end
    end
    // Channel bit shifter, first bit ends up at the top
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rx_shift_reg <= '0;
        end else if (rx_bit_valid_in && !rx_fbit) begin
            rx_shift_reg <= rx_full[6:0];
        end
    end
    // User bytes; bit 8 is dropped in data multiplex mode
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rx_byte_out <= '0;
            rx_byte_valid_out <= 1'b0;
        end else begin
            rx_byte_valid_out <= rx_slot_done && !rx_ch24_done;
            if (rx_slot_done && !rx_ch24_done) begin
                rx_byte_out.chan <= rx_slot_reg;
                rx_byte_out.data <= data_multiplex_format_in ? {1'b0, rx_full[7:1]}
                                                             : rx_full; // [R7]
            end
        end
    end
    // Slot 24 decode: alignment check, yellow alarm, A channel
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rx_yellow_alarm_out <= 1'b0;
            rx_dm_link_bit_out <= 1'b0;
            rx_dm_link_valid_out <= 1'b0;
            rx_sync_error_out <= 1'b0;
        end else begin
            rx_dm_link_valid_out <= rx_ch24_done; // [R13]
            rx_sync_error_out <= rx_ch24_done
                                 && ((rx_rev & SYNC_MASK) != SYNC_BYTE); // [R3]
            if (rx_ch24_done) begin
                rx_yellow_alarm_out <= !rx_rev[YEL_POS]; // [R13]
                rx_dm_link_bit_out <= rx_rev[DL_POS]; // [R13]
            end
        end
    end
    // Loop-carrier link collection, handed over after the last link frame
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rx_shadow_reg <= '0;
            rx_link_out <= '0;
            rx_link_valid_out <= 1'b0;
        end else begin
            rx_link_valid_out <= 1'b0;
            if (rx_bit_valid_in && rx_fbit && rx_in_link) begin
                if (rx_link_idx == LINK_LAST_IDX) begin
                    rx_link_out <= t1fr_link_unpack({rx_bit_in, rx_shadow_reg}); // [R14]
                    rx_link_valid_out <= 1'b1; // [R14]
                end else begin
                    rx_shadow_reg[rx_link_idx] <= rx_bit_in;
                end
            end
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    sequence s_dm_ch24_req;
        tx_bit_req_in && (tx_phase_reg == PH_CHAN) && tx_is_sync;
    endsequence
    sequence s_rx_ch24;
        rx_ch24_done;
    endsequence
    sequence s_rx_last_link;
        rx_bit_valid_in && rx_fbit && rx_in_link && (rx_link_idx == LINK_LAST_IDX);
    endsequence
    a_user_byte_out: assert property (tx_bit_req_in && tx_slot_start && !tx_is_sync // [R1]
        && data_multiplex_format_in && fifo_valid |=> tx_bit_out == $past(fifo_data[6]))
        else $error("user byte first bit wrong");
    a_ch24_no_pop: assert property (s_dm_ch24_req |=> $stable(u_fifo.rd_ptr_reg)) // [R2]
        else $error("user byte taken in slot 24");
    a_sync_pattern: assert property (s_dm_ch24_req ##0 SYNC_MASK[tx_bitpos_reg] // [R3]
        |=> tx_bit_out == SYNC_BYTE[$past(tx_bitpos_reg)])
        else $error("slot 24 sync pattern wrong");
    a_yellow_send: assert property (s_dm_ch24_req ##0 (tx_bitpos_reg == YEL_POS) // [R4]
        |=> tx_bit_out == !$past(tx_yellow_alarm_in))
        else $error("yellow bit wrong");
    a_a_channel: assert property (s_dm_ch24_req ##0 (tx_bitpos_reg == DL_POS) // [R5]
        |=> tx_bit_out == $past(tx_dm_link_bit_in))
        else $error("A channel bit wrong");
    a_reserved_bit: assert property (tx_bit_req_in && (tx_phase_reg == PH_CHAN) // [R7]
        && data_multiplex_format_in && !tx_is_sync && (tx_bitpos_reg == RES_BIT)
        |=> tx_bit_out) else $error("reserved bit not one");
    a_terminal_fbit: assert property (tx_bit_req_in && (tx_phase_reg == PH_FBIT) // [R9]
        && !tx_frame_reg[0] |=> tx_bit_out == ($past(tx_frame_reg[1:0]) == 2'b00))
        else $error("terminal framing bit wrong");
    a_signal_fbit: assert property (tx_bit_req_in && (tx_phase_reg == PH_FBIT) // [R11]
        && tx_frame_reg[0] && !tx_in_link |=> tx_bit_out == FS_PATTERN[$past(tx_sf_reg)])
        else $error("signaling framing bit wrong");
    a_loop_link_fbit: assert property (tx_bit_req_in && (tx_phase_reg == PH_FBIT) // [R10]
        && tx_in_link |=> tx_bit_out == $past(tx_link_bit))
        else $error("loop link bit wrong");
    a_robbed_bit: assert property (tx_bit_req_in && (tx_phase_reg == PH_CHAN) // [R12]
        && !data_multiplex_format_in && (tx_bitpos_reg == LAST_BIT)
        && ((tx_sf_reg == SF_SIG_A) || (tx_sf_reg == SF_SIG_B))
        |=> tx_bit_out == $past(tx_rob_bit)) else $error("robbed bit wrong");
    a_rx_yellow: assert property (s_rx_ch24 |=> rx_dm_link_valid_out // [R13]
        && (rx_yellow_alarm_out == !$past(rx_rev[YEL_POS]))) else $error("rx yellow wrong");
    a_rx_sync_err: assert property (s_rx_ch24 ##0 ((rx_rev & SYNC_MASK) != SYNC_BYTE) // [R3]
        |=> rx_sync_error_out) else $error("rx sync error missed");
    a_rx_link_once: assert property (s_rx_last_link |=> rx_link_valid_out // [R14]
        ##1 !rx_link_valid_out) else $error("rx link hand-over wrong");
endmodule

// ---- design/t1fr_pkg.sv ----
// Shared constants, carrier types and helpers for the T1 framer.
package t1fr_pkg;

    // ==========================================================
    // Frame geometry
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 8;
    localparam logic [6:0] SF_LAST_FRAME = 7'h0B;
    localparam logic [6:0] LOOP_LAST_FRAME = 7'h47;
    localparam logic [3:0] SF_LAST = 4'hB;
    localparam logic [3:0] SF_SIG_A = 4'h5;
    localparam logic [3:0] SF_SIG_B = 4'hB;
    localparam logic [4:0] LAST_SLOT = 5'h17;
    localparam logic [4:0] SYNC_SLOT = 5'h17;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [2:0] DM_MSB = 3'h6;

    // ==========================================================
    // Channel-24 layout in the data multiplex format
    localparam logic [7:0] SYNC_BYTE = 8'h1D;
    localparam logic [7:0] SYNC_MASK = 8'h9F;
    localparam logic [2:0] YEL_POS = 3'h5;
    localparam logic [2:0] DL_POS = 3'h6;
    localparam logic [2:0] RES_BIT = 3'h7;
    localparam logic [7:0] IDLE_BYTE = 8'hFF;

    // ==========================================================
    // F-bit patterns and loop-carrier link region
    localparam logic [11:0] FS_PATTERN = 12'h2A0;
    localparam logic [6:0] LINK_FIRST = 7'h0B;
    localparam logic [6:0] LINK_LAST = 7'h39;
    localparam logic [4:0] LINK_LAST_IDX = 5'h17;
    localparam logic [2:0] SPOILER_MID = 3'h2;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [3:0] protection_switch_bits;
        logic [1:0] loop_alarm_bits;
        logic [2:0] maintenance_bits;
        logic [10:0] concentrator_bits;
    } t1fr_link_t;

    typedef struct packed {
        logic [4:0] chan;
        logic [7:0] data;
    } t1fr_chan_byte_t;

    typedef enum logic {PH_FBIT, PH_CHAN} t1fr_phase_t;

    // Link bits in send order, index 0 is the first even frame of the region
    function automatic logic [23:0] t1fr_link_vec(input t1fr_link_t l);
        t1fr_link_vec = {1'b1, l.protection_switch_bits, l.loop_alarm_bits,
                         l.maintenance_bits, SPOILER_MID, l.concentrator_bits};
    endfunction

    function automatic t1fr_link_t t1fr_link_unpack(input logic [23:0] v);
        t1fr_link_t l;
        l.concentrator_bits = v[10:0];
        l.maintenance_bits = v[16:14];
        l.loop_alarm_bits = v[18:17];
        l.protection_switch_bits = v[22:19];
        return l;
    endfunction

endpackage

// ---- testbench/t1fr_bench.sv ----
// Self-checking bench: data multiplex, loop carrier and corrupted-line runs.
module t1_data_mux_and_loop_carrier_framing_bench
    import t1fr_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, srst = 1'b1, mode = 1'b1, valid = 1'b0;
    logic run = 1'b0, corrupt = 1'b0, yel = 1'b0, dml = 1'b0;
    logic [3:0] gap = 4'h2;
    logic [7:0] data = 8'h00;
    logic [7:0] sent [8];
    logic [23:0] sig_a = 24'h5AC3F0, sig_b = 24'h0F3C96;
    t1fr_link_t link = 20'hB35A3;
    t1fr_link_t rlink;
    t1fr_chan_byte_t rxbyte, first_rb;
    logic req, txb, fst, rxb, rxv, rxs, ready, rbv, ryel, rdl, rdlv, rse, rlv;
    int err_count = 0, checked = 0, n_se, n_dlv, n_lv, n_rb;
    // ==========
    // Clock, design and line partner
    always #20 clk = ~clk;
    t1fr_framer dut (.clk_in(clk), .srst_in(srst), .data_multiplex_format_in(mode),
        .tx_data_in(data), .tx_valid_in(valid), .tx_ready_out(ready),
        .tx_sig_a_in(sig_a), .tx_sig_b_in(sig_b), .tx_yellow_alarm_in(yel),
        .tx_dm_link_bit_in(dml), .tx_link_in(link), .tx_bit_req_in(req),
        .tx_bit_out(txb), .tx_frame_start_out(fst), .rx_bit_in(rxb),
        .rx_bit_valid_in(rxv), .rx_frame_sync_in(rxs), .rx_byte_out(rxbyte),
        .rx_byte_valid_out(rbv), .rx_yellow_alarm_out(ryel), .rx_dm_link_bit_out(rdl),
        .rx_dm_link_valid_out(rdlv), .rx_sync_error_out(rse), .rx_link_out(rlink),
        .rx_link_valid_out(rlv));
    t1fr_line_model lm (.clk_in(clk), .srst_in(srst), .run_in(run), .gap_in(gap),
        .corrupt_in(corrupt), .tx_bit_in(txb), .tx_frame_start_in(fst),
        .tx_bit_req_out(req), .rx_bit_out(rxb), .rx_bit_valid_out(rxv),
        .rx_frame_sync_out(rxs));
    // Count receive pulses of the running test
    always @(posedge clk) begin
        if (rbv && n_rb == 0) first_rb = rxbyte;
        if (rbv) n_rb++;
        if (rse) n_se++;
        if (rdlv) n_dlv++;
        if (rlv) n_lv++;
    end
    // ==========
    // Shared tasks
    task automatic report_and_stop(input bit hang);
        if (hang) err_count++;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Expected line bit p of frame f; only frame 0 carries the queued bytes
    function automatic logic exp_bit(input int f, p);
        int s, k;
        logic [7:0] b, v;
        logic [23:0] lv;
        s = (p - 1) / 8;
        k = (p - 1) % 8;
        lv = {1'b1, link.protection_switch_bits, link.loop_alarm_bits,
              link.maintenance_bits, 3'h2, link.concentrator_bits};
        v = {1'b0, dml, ~yel, 5'h1D};
        b = (f == 0 && s < 8) ? sent[s] : 8'hFF;
        if (p == 0) begin
            if (f % 2 == 0) return (f % 4 == 0);
            if (!mode && f >= 11 && f <= 57) return lv[(f - 11) / 2];
            return (6'h1C >> ((f % 12) / 2)) & 6'h01;
        end
        if (mode) return (s == 23) ? v[k] : ((k == 7) ? 1'b1 : b[6 - k]);
        if (k == 7 && f % 12 == 5) return sig_a[s];
        if (k == 7 && f % 12 == 11) return sig_b[s];
        return b[7 - k];
    endfunction
    task automatic start(input logic m, input logic [3:0] g, input int cyc);
        srst = 1'b1;
        mode = m;
        gap = g;
        repeat (cyc) @(posedge clk);
        #1 srst = 1'b0;
        n_se = 0;
        n_dlv = 0;
        n_lv = 0;
        n_rb = 0;
    endtask
    // Fill the FIFO with the line stalled until it refuses
    task automatic fill();
        int i, t;
        for (i = 0; i < 8; i++) begin
            sent[i] = 8'h96 ^ 8'(i * 19);
            data = sent[i];
            valid = 1'b1;
            for (t = 0; t < 20 && ready !== 1'b1; t++) @(posedge clk) #1;
            if (t == 20) report_and_stop(1'b1);
            @(posedge clk) #1;
        end
        valid = 1'b0;
        check("tx_ready_out", ready, 1'b0);
    endtask
    task automatic run_line(input int n);
        int t;
        run = 1'b1;
        for (t = 0; t < n * 4 + 100 && lm.bits.size() < n; t++) @(posedge clk) #1;
        run = 1'b0;
        if (t == n * 4 + 100) report_and_stop(1'b1);
        repeat (4) @(posedge clk) #1;
    endtask
    task automatic cmp_frames(input int nf);
        int f, p;
        for (f = 0; f < nf; f++)
            for (p = 0; p < 193; p++)
                if (p == 0) check("f_bit", lm.bits[f * 193], exp_bit(f, 0));
                else check("slot_bit", lm.bits[f * 193 + p], exp_bit(f, p));
    endtask
    // ==========
    // Scenarios
    task automatic test_dm();
        start(1'b1, 4'h2, 12);
        yel = 1'b1;
        dml = 1'b1;
        // Host leaves zero substitution off; every user slot keeps bit 8 high
        fill();
        run_line(12 * 193);
        cmp_frames(12);
        check("rx_yellow", ryel, 1'b1);
        check("rx_dm_link", rdl, 1'b1);
        check("dm_link_pulses", n_dlv, 12);
        check("sync_errors", n_se, 0);
        check("rx_first_byte", first_rb, {5'h00, 1'b0, sent[0][6:0]});
        check("rx_bytes", n_rb, 12 * 23);
        $display("test_dm done");
    endtask
    // Slow line pacing over a whole 72-frame multiframe
    task automatic test_loop();
        start(1'b0, 4'h3, 2);
        fill();
        run_line(72 * 193);
        cmp_frames(72);
        check("rx_link", rlink, link);
        check("link_pulses", n_lv, 1);
        check("rx_first_byte", first_rb, {5'h00, sent[0]});
        $display("test_loop done");
    endtask
    // Inverted line: alignment pattern breaks, no-alarm bit reads as alarm
    task automatic test_corrupt();
        start(1'b1, 4'h1, 2);
        yel = 1'b0;
        dml = 1'b0;
        fill();
        corrupt = 1'b1;
        run_line(193);
        corrupt = 1'b0;
        cmp_frames(1);
        check("sync_errors", n_se, 1);
        check("rx_yellow", ryel, 1'b1);
        check("rx_dm_link", rdl, 1'b1);
        $display("test_corrupt done");
    endtask
    initial begin
        test_dm();
        test_loop();
        test_corrupt();
        report_and_stop(1'b0);
    end
endmodule

// ---- testbench/t1fr_line_model.sv ----
// Line-side partner: paces bit requests, records sent bits, loops them back.
module t1fr_line_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // Bench control
    input wire logic run_in,
    input wire logic [3:0] gap_in,
    input wire logic corrupt_in,
    // Framer transmit side
    input wire logic tx_bit_in,
    input wire logic tx_frame_start_in,
    output logic tx_bit_req_out,
    // Framer receive side
    output logic rx_bit_out,
    output logic rx_bit_valid_out,
    output logic rx_frame_sync_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic bits [$];
    logic pend_reg;
    logic [3:0] gap_reg;
    // ==========
    // Request pacing; a gap of 1 gives back-to-back requests
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            tx_bit_req_out <= 1'b0;
            gap_reg <= 4'h0;
        end else if (run_in && gap_reg == 4'h0) begin
            tx_bit_req_out <= 1'b1;
            gap_reg <= gap_in - 4'h1;
        end else begin
            tx_bit_req_out <= 1'b0;
            gap_reg <= (gap_reg == 4'h0) ? 4'h0 : gap_reg - 4'h1;
        end
    end
    // ==========
    // Capture a cycle after the request; idle data toggles so nothing stale reads
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pend_reg <= 1'b0;
            rx_bit_valid_out <= 1'b0;
            rx_frame_sync_out <= 1'b0;
            rx_bit_out <= 1'b0;
            bits.delete();
        end else begin
            pend_reg <= tx_bit_req_out;
            rx_bit_valid_out <= pend_reg;
            rx_frame_sync_out <= pend_reg & tx_frame_start_in;
            rx_bit_out <= pend_reg ? (tx_bit_in ^ corrupt_in) : ~rx_bit_out;
            if (pend_reg) bits.push_back(tx_bit_in);
        end
    end
endmodule
